// >>> hw/spsp_pkg.sv
package spsp_pkg;
    // =====================================================
    // section layout
    localparam logic [11:0] HDR_LAST = 12'd7;
    localparam logic [11:0] LEN_HI = 12'd1;
    localparam logic [11:0] LEN_LO = 12'd2;
    localparam logic [11:0] LEN_ADJ = 12'd2;
    localparam logic [3:0] F_LABEL = 4'd0;
    localparam logic [3:0] F_CODE = 4'd9;
    localparam logic [3:0] F_MOD = 4'd10;
    localparam logic [3:0] F_PAY = 4'd11;
    localparam logic [3:0] F_COMMIT = 4'd12;
    localparam logic [3:0] F_FLAGS2 = 4'd13;
    localparam logic [7:0] PERM_BYTES = 8'd7;
    localparam int CB_TURBO = 7;
    localparam int CB_ORDER = 6;
    localparam int CB_OUTER = 4;
    localparam int CB_PUNC = 0;
    localparam int MB_MOD = 3;
    localparam int MB_SHP = 0;
    localparam int F2_PERM = 0;
    // =====================================================
    // registers
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_SEL = 8'h08;
    localparam logic [7:0] REG_ENT0 = 8'h0C;
    localparam logic [7:0] REG_ENT1 = 8'h10;
    localparam logic [7:0] REG_ENT2 = 8'h14;
    localparam logic [7:0] REG_ENT3 = 8'h18;
    localparam int CTRL_EN = 0;
    localparam int CTRL_ALT = 1;
    localparam int CTRL_PID = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // =====================================================
    // codes
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [1:0] OUT_BOTH = 2'h0;
    localparam logic [1:0] OUT_RS = 2'h1;
    localparam logic [1:0] OUT_CRC = 2'h2;
    localparam logic [3:0] PUNC_LAST = 4'hC;
    localparam logic [3:0] PUNC_OMIT = 4'hF;
    localparam logic [4:0] MOD_BPSK = 5'h05;
    localparam logic [2:0] SHP_035 = 3'h0;
    localparam logic [2:0] SHP_020 = 3'h2;
    localparam logic [7:0] PAY_CELL = 8'h01;
    localparam logic [7:0] PAY_TS = 8'h05;
    localparam logic [7:0] PAY_CTL = 8'h06;
    localparam logic [7:0] PAY_ACQ = 8'h07;
    localparam logic [7:0] PAY_SYN = 8'h08;

    typedef enum logic [2:0] {PC_RSVD, PC_CELL, PC_TS, PC_CTL, PC_ACQ, PC_SYN, PC_USER} spsp_pay_t;
    typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_COUNT, ST_ENT, ST_PERM, ST_PLEN, ST_PRE, ST_TAIL} spsp_st_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic [12:0] pid;
        logic [7:0] data;
    } spsp_byte_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } spsp_bus_t;

    typedef struct packed {
        logic [7:0] label;
        logic [23:0] sym_rate;
        logic [23:0] duration;
        logic [15:0] offset;
        logic turbo;
        logic reverse;
        logic [1:0] outer;
        logic [3:0] punct;
        logic [4:0] modul;
        logic [2:0] shaping;
        logic [7:0] payload;
    } spsp_entry_t;

    typedef struct packed {
        logic continuous;
        logic fixed;
        logic rev_eff;
        logic rs_on;
        logic crc_on;
        logic omitted;
        logic [3:0] rate_num;
        logic [3:0] rate_den;
        logic spread;
        logic spread_qpsk;
        logic [4:0] sf;
        logic [1:0] roll;
        spsp_pay_t pay;
        logic code_err;
    } spsp_dec_t;
endpackage

// >>> hw/spsp_crc32.sv
`timescale 1ns/1ps
module spsp_crc32 (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic init_i,
    input wire logic [7:0] data_i,
    output logic [31:0] crc_o
);
    import spsp_pkg::*;

    logic [31:0] crc;
    logic [31:0] next_crc;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ CRC_POLY) : {r[30:0], 1'b0};
        end
        return r;
    endfunction

    always_comb
    begin
        next_crc = crc;
        if (en_i)
        begin
            next_crc = crc_byte(init_i ? CRC_INIT : crc, data_i);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            crc <= CRC_INIT;
        end
        else
        begin
            crc <= next_crc;
        end
    end

    assign crc_o = crc;
endmodule // spsp_crc32

// >>> hw/spsp_code_dec.sv
`timescale 1ns/1ps
module spsp_code_dec (
    input spsp_pkg::spsp_entry_t ent_i,
    input wire logic alt_i,
    output spsp_pkg::spsp_dec_t dec_o
);
    import spsp_pkg::*;

    function automatic logic [7:0] rate_of(input logic [3:0] p);
        case (p)
            4'd0: return 8'h12;
            4'd1: return 8'h23;
            4'd2: return 8'h34;
            4'd3: return 8'h56;
            4'd4: return 8'h78;
            4'd5: return 8'h13;
            4'd6: return 8'h25;
            4'd7: return 8'h45;
            4'd8: return 8'h67;
            4'd9: return 8'h14;
            4'd10: return 8'h35;
            4'd11: return 8'h89;
            4'd12: return 8'h9A;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [4:0] sf_of(input logic [2:0] b);
        case (b)
            3'd0: return 5'd2;
            3'd1: return 5'd3;
            3'd2: return 5'd4;
            3'd3: return 5'd6;
            3'd4: return 5'd8;
            3'd5: return 5'd10;
            3'd6: return 5'd13;
            default: return 5'd16;
        endcase
    endfunction

    always_comb
    begin
        dec_o = '0;
        dec_o.continuous = (ent_i.duration == 24'h00_0000);
        dec_o.fixed = dec_o.continuous && !alt_i;
        dec_o.rev_eff = ent_i.turbo && ent_i.reverse;
        dec_o.rs_on = (ent_i.outer == OUT_RS) || (ent_i.outer == OUT_BOTH);
        dec_o.crc_on = (ent_i.outer == OUT_CRC) || (ent_i.outer == OUT_BOTH);
        dec_o.omitted = (ent_i.punct == PUNC_OMIT);
        {dec_o.rate_num, dec_o.rate_den} = rate_of(ent_i.punct);
        dec_o.spread = ent_i.modul[4];
        dec_o.spread_qpsk = ent_i.modul[4] && ent_i.modul[3];
        dec_o.sf = ent_i.modul[4] ? sf_of(ent_i.modul[2:0]) : 5'd1;
        dec_o.roll = ent_i.shaping[1:0];
        case (ent_i.payload)
            PAY_CELL: dec_o.pay = PC_CELL;
            PAY_TS: dec_o.pay = PC_TS;
            PAY_CTL: dec_o.pay = PC_CTL;
            PAY_ACQ: dec_o.pay = PC_ACQ;
            PAY_SYN: dec_o.pay = PC_SYN;
            default: dec_o.pay = ent_i.payload[7] ? PC_USER : PC_RSVD;
        endcase
        // continuous-only roll-offs are invalid on a burst slot
        dec_o.code_err = (ent_i.punct > PUNC_LAST && !dec_o.omitted)
            || (!ent_i.modul[4] && (ent_i.modul == 5'h00 || ent_i.modul > MOD_BPSK))
            || (ent_i.shaping > SHP_020)
            || (ent_i.shaping != SHP_035 && !dec_o.continuous);
    end
endmodule // spsp_code_dec

// >>> hw/spsp_parser.sv
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module spsp_parser (
    input wire logic clk_i,
    input wire logic rst_i,
    input spsp_pkg::spsp_byte_t byte_i,
    input spsp_pkg::spsp_bus_t bus_i,
    output logic [31:0] rdata_o,
    output spsp_pkg::spsp_entry_t entry_o,
    output spsp_pkg::spsp_dec_t dec_o,
    output logic entry_valid_o,
    output logic code_err_o,
    output logic sec_ok_o,
    output logic sec_err_o
);
    import spsp_pkg::*;

    typedef struct packed {
        spsp_st_t st;
        logic [11:0] bidx;
        logic [11:0] len;
        logic [7:0] ecount;
        logic [3:0] fidx;
        logic [7:0] skip;
        spsp_entry_t ent;
        spsp_entry_t out;
        spsp_dec_t dec;
        logic chk;
        logic [255:0] pend;
        logic [255:0] valid;
        logic [7:0] n_ok;
        logic [7:0] n_crc;
        logic [7:0] n_code;
        logic [31:0] ctrl;
        logic [7:0] sel;
        logic [31:0] rdata;
        logic ent_v;
        logic ok_p;
        logic err_p;
        logic cerr_p;
    } spsp_state_t;

    spsp_state_t s;
    spsp_state_t next_s;
    spsp_dec_t dec;
    logic [31:0] crc;
    logic acc;
    logic wr_en;
    spsp_entry_t tbl [256];
    spsp_entry_t rd_ent;

    // =====================================================
    // input qualification and helpers
    assign acc = byte_i.valid && s.ctrl[CTRL_EN]
        && (byte_i.pid == s.ctrl[CTRL_PID +: 13]);

    spsp_crc32 u_crc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(acc),
        .init_i(byte_i.first),
        .data_i(byte_i.data),
        .crc_o(crc)
    );

    spsp_code_dec u_dec (
        .ent_i(s.ent),
        .alt_i(s.ctrl[CTRL_ALT]),
        .dec_o(dec)
    );

    assign rd_ent = tbl[s.sel];

    // =====================================================
    // next state
    always_comb
    begin
        next_s = s;
        wr_en = 1'b0;
        next_s.ent_v = 1'b0;
        next_s.ok_p = 1'b0;
        next_s.err_p = 1'b0;
        next_s.cerr_p = 1'b0;
        next_s.chk = 1'b0;
        next_s.rdata = 32'h0000_0000;
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                REG_CTRL: next_s.ctrl = bus_i.wdata;
                REG_SEL: next_s.sel = bus_i.wdata[7:0];
                default: ;
            endcase
        end
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                REG_CTRL: next_s.rdata = s.ctrl;
                REG_STAT: next_s.rdata = {7'h00, s.st != ST_IDLE, s.n_code, s.n_crc, s.n_ok};
                REG_SEL: next_s.rdata = {24'h00_0000, s.sel};
                REG_ENT0: next_s.rdata = {s.valid[s.sel], 7'h00, rd_ent.sym_rate};
                REG_ENT1: next_s.rdata = {7'h00, rd_ent.duration == 24'h00_0000, rd_ent.duration};
                REG_ENT2: next_s.rdata = {8'h00, rd_ent.payload, rd_ent.offset};
                REG_ENT3: next_s.rdata = {16'h0000, rd_ent.shaping, rd_ent.modul, rd_ent.punct,
                    rd_ent.outer, rd_ent.reverse, rd_ent.turbo};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        // verdict one cycle after the last byte, once the crc holds it
        if (s.chk)
        begin
            if (crc == 32'h0000_0000 && s.st == ST_TAIL)
            begin
                next_s.valid = s.valid | s.pend;
                next_s.ok_p = 1'b1;
                next_s.n_ok = s.n_ok + 8'd1;
            end
            else
            begin
                // overwritten labels cannot be restored, so they are dropped
                next_s.valid = s.valid & ~s.pend;
                next_s.err_p = 1'b1;
                next_s.n_crc = s.n_crc + 8'd1;
            end
            next_s.pend = '0;
            next_s.st = ST_IDLE;
        end
        if (acc && byte_i.first)
        begin
            next_s.st = ST_HDR;
            next_s.bidx = 12'd1;
            next_s.pend = '0;
        end
        else if (acc && s.st != ST_IDLE)
        begin
            next_s.bidx = s.bidx + 12'd1;
            if (s.st != ST_HDR && s.bidx == s.len + LEN_ADJ)
            begin
                next_s.chk = 1'b1;
            end
            case (s.st)
                ST_HDR:
                begin
                    if (s.bidx == LEN_HI)
                    begin
                        next_s.len[11:8] = byte_i.data[3:0];
                    end
                    if (s.bidx == LEN_LO)
                    begin
                        next_s.len[7:0] = byte_i.data;
                    end
                    if (s.bidx == HDR_LAST)
                    begin
                        next_s.st = ST_COUNT;
                    end
                end
                ST_COUNT:
                begin
                    next_s.ecount = byte_i.data;
                    next_s.st = ST_ENT;
                    next_s.fidx = F_LABEL;
                end
                ST_ENT:
                begin
                    next_s.fidx = s.fidx + 4'd1;
                    if (s.fidx == F_LABEL)
                    begin
                        next_s.ent.label = byte_i.data;
                    end
                    else if (s.fidx < 4'd4)
                    begin
                        next_s.ent.sym_rate = {s.ent.sym_rate[15:0], byte_i.data};
                    end
                    else if (s.fidx < 4'd7)
                    begin
                        next_s.ent.duration = {s.ent.duration[15:0], byte_i.data};
                    end
                    else if (s.fidx < F_CODE)
                    begin
                        next_s.ent.offset = {s.ent.offset[7:0], byte_i.data};
                    end
                    else if (s.fidx == F_CODE)
                    begin
                        next_s.ent.turbo = byte_i.data[CB_TURBO];
                        next_s.ent.reverse = byte_i.data[CB_ORDER];
                        next_s.ent.outer = byte_i.data[CB_OUTER +: 2];
                        next_s.ent.punct = byte_i.data[CB_PUNC +: 4];
                    end
                    else if (s.fidx == F_MOD)
                    begin
                        next_s.ent.modul = byte_i.data[MB_MOD +: 5];
                        next_s.ent.shaping = byte_i.data[MB_SHP +: 3];
                    end
                    else if (s.fidx == F_PAY)
                    begin
                        next_s.ent.payload = byte_i.data;
                    end
                    else if (s.fidx == F_COMMIT)
                    begin
                        if (dec.code_err)
                        begin
                            next_s.cerr_p = 1'b1;
                            next_s.n_code = s.n_code + 8'd1;
                        end
                        else
                        begin
                            wr_en = 1'b1;
                            next_s.pend[s.ent.label] = 1'b1;
                            next_s.ent_v = 1'b1;
                            next_s.out = s.ent;
                            next_s.dec = dec;
                        end
                    end
                    else
                    begin
                        // trailing permutation only for turbo with new parameters
                        if (s.ent.turbo && byte_i.data[F2_PERM])
                        begin
                            next_s.st = ST_PERM;
                            next_s.skip = PERM_BYTES;
                        end
                        else
                        begin
                            next_s.st = ST_PLEN;
                        end
                    end
                end
                ST_PERM:
                begin
                    next_s.skip = s.skip - 8'd1;
                    if (s.skip == 8'd1)
                    begin
                        next_s.st = ST_PLEN;
                    end
                end
                ST_PLEN:
                begin
                    // two bits per symbol, padded to whole bytes
                    next_s.skip = {2'b00, byte_i.data[7:2]} + {7'h00, byte_i.data[1:0] != 2'b00};
                    if (byte_i.data == 8'h00)
                    begin
                        next_s.st = (s.ecount == 8'h00) ? ST_TAIL : ST_ENT;
                        next_s.ecount = s.ecount - {7'h00, s.ecount != 8'h00};
                        next_s.fidx = F_LABEL;
                    end
                    else
                    begin
                        next_s.st = ST_PRE;
                    end
                end
                ST_PRE:
                begin
                    next_s.skip = s.skip - 8'd1;
                    if (s.skip == 8'd1)
                    begin
                        next_s.st = (s.ecount == 8'h00) ? ST_TAIL : ST_ENT;
                        next_s.ecount = s.ecount - {7'h00, s.ecount != 8'h00};
                        next_s.fidx = F_LABEL;
                    end
                end
                default: ;
            endcase
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.st <= ST_IDLE;
            s.ctrl <= CTRL_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (wr_en)
        begin
            tbl[s.ent.label] <= s.ent;
        end
    end

    assign rdata_o = s.rdata;
    assign entry_o = s.out;
    assign dec_o = s.dec;
    assign entry_valid_o = s.ent_v;
    assign code_err_o = s.cerr_p;
    assign sec_ok_o = s.ok_p;
    assign sec_err_o = s.err_p;

    // =====================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_byte_in(spsp_st_t st);
        acc && !byte_i.first && s.st == st;
    endsequence

    sequence s_commit;
        s_byte_in(ST_ENT) ##0 s.fidx == F_COMMIT;
    endsequence

    chk_hdr_len: assert property (s_byte_in(ST_HDR) ##0 s.bidx == HDR_LAST |=> s.st == ST_COUNT)
        else $error("header not 8 bytes");
    chk_count_load: assert property (s_byte_in(ST_COUNT) |=> s.ecount == $past(byte_i.data) && s.st == ST_ENT)
        else $error("entry count not loaded");
    chk_label_key: assert property (s_byte_in(ST_ENT) ##0 s.fidx == F_LABEL |=> s.ent.label == $past(byte_i.data))
        else $error("label not captured");
    chk_rate_bytes: assert property (s_byte_in(ST_ENT) ##0 s.fidx == 4'd3 |=> s.ent.sym_rate[7:0] == $past(byte_i.data))
        else $error("symbol rate low byte wrong");
    chk_commit_out: assert property (s_commit ##0 !dec.code_err |=> entry_valid_o && entry_o == $past(s.ent))
        else $error("good entry not presented");
    chk_cont_zero: assert property (entry_valid_o |-> dec_o.continuous == (entry_o.duration == 24'h00_0000))
        else $error("continuous flag wrong");
    chk_drop_bad: assert property (s_commit ##0 dec.code_err |=> code_err_o && !entry_valid_o)
        else $error("bad entry not dropped");
    chk_modul_undef: assert property (s.ent.modul == 5'h00 |-> dec.code_err)
        else $error("undefined modulation accepted");
    chk_spread_sf: assert property (s.ent.modul == 5'h1D |-> dec.sf == 5'd10 && dec.spread_qpsk)
        else $error("spreading decode wrong");
    chk_crc_gate: assert property (s.chk |=> (sec_ok_o == ($past(crc) == 32'h0000_0000 && $past(s.st) == ST_TAIL)))
        else $error("section verdict wrong");
endmodule // spsp_parser

// >>> test/spsp_demux_model.sv
`timescale 1ns/1ps
module spsp_demux_model (
    input wire logic clk_i,
    output spsp_pkg::spsp_byte_t byte_o
);
    import spsp_pkg::*;
    logic [7:0] mem [0:63];
    initial byte_o = '0;
    // ==========
    // section out
    // idle cycles show inverted last byte, never a stale copy
    task automatic send(input int n, input logic [12:0] pid);
        for (int i = 0; i < n; i++)
        begin
            if (i % 5 == 4)
            begin
                @(posedge clk_i);
                byte_o <= {2'b00, ~pid, ~mem[i - 1]};
            end
            @(posedge clk_i);
            byte_o <= {1'b1, i == 0, pid, mem[i]};
        end
        @(posedge clk_i);
        byte_o <= {2'b00, ~pid, ~mem[n - 1]};
    endtask
endmodule // spsp_demux_model

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    import spsp_pkg::*;
    `define CHK(a, x) begin compares++; if ((a) !== (x)) begin failures++; $display("mismatch %0t %h %h", $time, a, x); end end
    localparam logic [12:0] PID = 13'h01A5;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    spsp_bus_t bus_i = '0;
    spsp_byte_t byte_i;
    spsp_entry_t entry_o;
    spsp_entry_t e;
    spsp_dec_t dec_o;
    logic [31:0] rdata_o;
    logic [31:0] d;
    logic entry_valid_o, code_err_o, sec_ok_o, sec_err_o;
    int failures = 0, compares = 0, n_ent = 0, n_err = 0, n_ok = 0, n_bad = 0, k, a, b, v;
    always #5 clk_i = ~clk_i;
    spsp_demux_model pm (.clk_i(clk_i), .byte_o(byte_i));
    spsp_parser dut (.clk_i(clk_i), .rst_i(rst_i), .byte_i(byte_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .entry_o(entry_o), .dec_o(dec_o), .entry_valid_o(entry_valid_o), .code_err_o(code_err_o),
        .sec_ok_o(sec_ok_o), .sec_err_o(sec_err_o));
    always @(posedge clk_i)
    begin
        n_ent <= n_ent + entry_valid_o;
        n_err <= n_err + code_err_o;
        n_ok <= n_ok + sec_ok_o;
        n_bad <= n_bad + sec_err_o;
    end
    // ==========
    // bus and stream helpers
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge clk_i);
        bus_i <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge clk_i);
        bus_i <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic put(input logic [7:0] v);
        pm.mem[k] = v;
        k++;
    endtask
    // crc kept here on purpose, independent of the design's engine
    task automatic build(input int ne, input logic [7:0] cd, md, input logic [23:0] dur);
        logic [31:0] c;
        k = 0;
        put(8'hA1);
        repeat (7) put(8'h00);
        put(8'(ne - 1));
        for (int i = 0; i < ne; i++)
        begin
            e = {8'(8'h10 + i), 24'h12_3456, dur, 16'hBEEF, cd, md, 8'h05};
            for (int j = 95; j > 0; j -= 8) put(e[j -: 8]);
            repeat (3) put(8'h00);
        end
        pm.mem[2] = 8'(k + 1);
        c = CRC_INIT;
        for (int i = 0; i < k * 8; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ pm.mem[i / 8][7 - i % 8]) ? CRC_POLY : 32'h0);
        for (int j = 31; j > 0; j -= 8) put(c[j -: 8]);
    endtask
    task automatic run(input logic [12:0] pid);
        a = n_ok + n_bad + n_ent;
        b = n_err;
        v = n_ok + n_bad;
        pm.send(k, pid);
        // wait until the verdict pulse is counted; bounded for ignored sections
        for (int i = 0; i < 40 && n_ok + n_bad == v; i++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask
    // ==========
    // scenarios
    task automatic t_pid;
        rd(REG_CTRL);
        `CHK(d, CTRL_RST)
        wr(REG_CTRL, {3'h0, PID, 16'h0001});
        build(1, 8'h00, 8'h08, 24'h00_1000);
        run(PID ^ 13'h0001);
        `CHK(n_ok + n_bad + n_ent - a, 0)
        $display("pid done");
    endtask
    task automatic t_good;
        build(2, 8'hE2, 8'hE8, 24'h00_0000);
        run(PID);
        `CHK(n_ent - a + n_ok + n_bad, 3)
        `CHK(sec_ok_o | sec_err_o, 1'b0)
        `CHK(entry_o, e)
        `CHK(dec_o.continuous, 1'b1)
        `CHK(dec_o.fixed, 1'b1)
        `CHK(dec_o.rev_eff, 1'b1)
        `CHK({dec_o.rs_on, dec_o.crc_on}, 2'b01)
        `CHK({dec_o.rate_num, dec_o.rate_den}, 8'h34)
        `CHK({dec_o.spread, dec_o.spread_qpsk}, 2'b11)
        `CHK(dec_o.sf, 5'h0A)
        `CHK(dec_o.pay, PC_TS)
        `CHK({dec_o.roll, dec_o.omitted, dec_o.code_err}, 4'h0)
        wr(REG_SEL, 32'h0000_0010);
        rd(REG_ENT0);
        `CHK(d, 32'h8012_3456)
        rd(REG_ENT1);
        `CHK(d, 32'h0100_0000)
        rd(REG_ENT2);
        `CHK(d, 32'h0005_BEEF)
        rd(REG_ENT3);
        `CHK(d, 32'h0000_1D2B)
        rd(8'hFC);
        `CHK(d, 32'h0000_0000)
        $display("good done");
    endtask
    task automatic t_codes;
        logic [15:0] tbl [3] = '{16'h0D08, 16'h0030, 16'h000B};
        foreach (tbl[i])
        begin
            build(1, tbl[i][15:8], tbl[i][7:0], 24'h00_1000);
            run(PID);
            `CHK(n_err - b, 1)
            `CHK(n_ent + n_ok + n_bad - a, 1)
        end
        build(1, 8'h00, 8'h08, 24'h00_1000);
        pm.mem[k - 1] ^= 8'h01;
        run(PID);
        `CHK(n_bad + n_ent + n_ok - a, 2)
        rd(REG_ENT0);
        `CHK(d[31], 1'b0)
        rd(REG_STAT);
        `CHK(d, 32'h0003_0104)
        $display("codes done");
    endtask
    task print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        print_verdict;
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_pid;
        t_good;
        t_codes;
        print_verdict;
    end
endmodule // tb
